//--- logic/pmcs_regs.vh
// Notes on behaviour
// - Loopback isolates medium, returns transmit data
// - Forced speed/duplex apply only without negotiation
// - Negotiation enable bit read/write, resets to one
// - Restart bit self-clears; inert when negotiation off
// - Control bits six to zero reserved
// - 100BASE-T4 capability always reads zero
// - Capability bits reset one, strapping may clear
// - Preamble suppression bit reads one
// - Negotiation complete only after negotiation finishes
// - Remote fault latches high until read
// - Link status latches low until read
// - Jabber latches high, zero at 100 Mbps
// - Negotiation ability follows strapped mode
// - Extended capability bit always reads one
// - Data line released while interface idle
`ifndef PMCS_REGS_VH
`define PMCS_REGS_VH

// Register addresses
`define PMCS_ADDR_CTRL      5'h00
`define PMCS_ADDR_STAT      5'h01
`define PMCS_PHY_ADDR       5'h00

// Control word fields
`define PMCS_CTL_SRST       15
`define PMCS_CTL_LOOP       14
`define PMCS_CTL_SPEED      13
`define PMCS_CTL_ANEN       12
`define PMCS_CTL_PDOWN      11
`define PMCS_CTL_ISO        10
`define PMCS_CTL_RESTART    9
`define PMCS_CTL_DUPLEX     8
`define PMCS_CTL_COLTEST    7

// Control and status reset values
`define PMCS_RST_LOOP       1'b0
`define PMCS_RST_SPEED      1'b1
`define PMCS_RST_ANEN       1'b1
`define PMCS_RST_PDOWN      1'b0
`define PMCS_RST_ISO        1'b0
`define PMCS_RST_DUPLEX     1'b0
`define PMCS_RST_COLTEST    1'b0
`define PMCS_RST_CAP        4'hF
`define PMCS_RST_ANABLE     1'b1

// Management frame codes
`define PMCS_OP_READ        2'h2
`define PMCS_OP_WRITE       2'h1
`define PMCS_HDR_LAST       4'hB
`define PMCS_DATA_LAST      4'hF

// Soft reset duration in core cycles
`define PMCS_SRST_CYCLES    4'h8
// Core cycles to wait before sampling straps
`define PMCS_STRAP_WAIT     2'h3

`endif

//--- logic/pmcs_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser, one stage pair per bit
module pmcs_sync #(
  parameter WIDTH = 7
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      reg stage1;
      reg stage2;
      // First stage is read only by the second
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= asyncIn[i];
          stage2 <= stage1;
        end
      end
      assign syncOut[i] = stage2;
    end
  endgenerate

endmodule // pmcs_sync

//--- logic/pmcs_phy_mgmt.v
`timescale 1ns/1ps
`include "pmcs_regs.vh"
module pmcs_phy_mgmt (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       mdcPin,
  input  wire       mdioIn,
  output reg        mdioOut,
  output reg        mdioOeN,
  input  wire [3:0] strapCap,
  input  wire       strapAnAble,
  input  wire       linkUp,
  input  wire       remoteFault,
  input  wire       jabber,
  input  wire       anDone,
  input  wire       anSpeed100,
  input  wire       anFullDuplex,
  input  wire       txEn,
  input  wire [3:0] txData,
  output reg        mediaTxEn,
  output reg  [3:0] mediaTxData,
  output reg        loopRxDv,
  output reg  [3:0] loopRxData,
  output reg        portSpeed100,
  output reg        portFullDuplex,
  output reg        anEnable,
  output reg        anRestart,
  output reg        powerDown,
  output reg        isolate,
  output reg        softResetActive
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge finding
  localparam ST_IDLE = 2'h0;
  localparam ST_HDR  = 2'h1;
  localparam ST_TA   = 2'h2;
  localparam ST_DATA = 2'h3;

  wire [6:0] pinSync;
  wire       mdcS;
  wire       mdioS;
  wire [3:0] capS;
  wire       anAbleS;
  reg        mdcD;
  wire       mdcRise;
  wire       mdcFall;

  pmcs_sync #(
    .WIDTH (7)
  ) uSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({strapAnAble, strapCap, mdioIn, mdcPin}),
    .syncOut (pinSync)
  );

  assign mdcS    = pinSync[0];
  assign mdioS   = pinSync[1];
  assign capS    = pinSync[5:2];
  assign anAbleS = pinSync[6];
  assign mdcRise = mdcS & ~mdcD;
  assign mdcFall = ~mdcS & mdcD;

  ////////////////////////////////////////////////////////////////////////
  // Management frame receiver
  reg  [1:0]  state;
  reg  [3:0]  bitCnt;
  reg         prevBit;
  reg  [10:0] hdr;
  reg  [14:0] wrShift;
  reg  [15:0] rdShift;
  reg         readHit;
  reg         writeHit;
  reg  [4:0]  regAddr;
  reg         statusRead;
  reg         writeStrobe;
  reg  [15:0] writeData;
  wire [11:0] hdrFull;
  wire [15:0] ctrlWord;
  wire [15:0] statWord;
  reg  [15:0] readMux;

  assign hdrFull = {hdr, mdioS};

  // Unmapped addresses of this port read as zero
  always @* begin
    case (hdrFull[4:0])
      `PMCS_ADDR_CTRL: readMux = ctrlWord;
      `PMCS_ADDR_STAT: readMux = statWord;
      default:         readMux = 16'h0000;
    endcase
  end

  // Start code 01 found without needing preamble
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdcD        <= 1'b0;
      state       <= ST_IDLE;
      bitCnt      <= 4'h0;
      prevBit     <= 1'b1;
      hdr         <= 11'h000;
      wrShift     <= 15'h0000;
      readHit     <= 1'b0;
      writeHit    <= 1'b0;
      regAddr     <= 5'h00;
      statusRead  <= 1'b0;
      writeStrobe <= 1'b0;
      writeData   <= 16'h0000;
    end else begin
      mdcD        <= mdcS;
      statusRead  <= 1'b0;
      writeStrobe <= 1'b0;
      if (mdcRise) begin
        case (state)
          ST_IDLE: begin
            prevBit <= mdioS;
            if (!prevBit && mdioS) begin
              state  <= ST_HDR;
              bitCnt <= 4'h0;
            end
          end
          ST_HDR: begin
            hdr    <= hdrFull[10:0];
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt == `PMCS_HDR_LAST) begin
              // Header is op, PHY address, register address
              state    <= ST_TA;
              bitCnt   <= 4'h0;
              regAddr  <= hdrFull[4:0];
              readHit  <= (hdrFull[11:10] == `PMCS_OP_READ) &&
                          (hdrFull[9:5] == `PMCS_PHY_ADDR);
              writeHit <= (hdrFull[11:10] == `PMCS_OP_WRITE) &&
                          (hdrFull[9:5] == `PMCS_PHY_ADDR);
              statusRead <= (hdrFull[11:10] == `PMCS_OP_READ) &&
                            (hdrFull[9:5] == `PMCS_PHY_ADDR) &&
                            (hdrFull[4:0] == `PMCS_ADDR_STAT);
            end
          end
          ST_TA: begin
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt == 4'h1) begin
              state  <= ST_DATA;
              bitCnt <= 4'h0;
            end
          end
          ST_DATA: begin
            wrShift <= {wrShift[13:0], mdioS};
            bitCnt  <= bitCnt + 4'h1;
            if (bitCnt == `PMCS_DATA_LAST) begin
              state       <= ST_IDLE;
              prevBit     <= 1'b1;
              writeStrobe <= writeHit;
              writeData   <= {wrShift, mdioS};
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line driver, changes on the falling clock edge
  // Snapshot taken with the header so a word never tears mid-read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdioOut <= 1'b1;
      mdioOeN <= 1'b1;
      rdShift <= 16'h0000;
    end else begin
      if (mdcRise && state == ST_HDR && bitCnt == `PMCS_HDR_LAST) begin
        rdShift <= readMux;
      end
      if (mdcFall) begin
        if (state == ST_TA && bitCnt == 4'h1 && readHit) begin
          mdioOut <= 1'b0;
          mdioOeN <= 1'b0;
        end else if (state == ST_DATA && readHit) begin
          mdioOut <= rdShift[15];
          mdioOeN <= 1'b0;
          rdShift <= {rdShift[14:0], 1'b0};
        end else begin
          mdioOut <= 1'b1;
          mdioOeN <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  reg [1:0] strapWait;
  reg [3:0] capBits;
  reg       anAble;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapWait <= 2'h0;
      capBits   <= `PMCS_RST_CAP;
      anAble    <= `PMCS_RST_ANABLE;
    end else if (strapWait != `PMCS_STRAP_WAIT) begin
      strapWait <= strapWait + 2'h1;
      if (strapWait == `PMCS_STRAP_WAIT - 2'h1) begin
        capBits <= capS;
        anAble  <= anAbleS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control word
  reg [3:0] srCnt;
  reg       loopBit;
  reg       speedBit;
  reg       duplexBit;
  reg       colTest;
  reg       restartBit;
  reg       anDoneD;
  wire      anDoneRise;
  wire      srBusy;

  assign anDoneRise = anDone & ~anDoneD;
  assign srBusy     = (srCnt != 4'h0);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srCnt      <= 4'h0;
      loopBit    <= `PMCS_RST_LOOP;
      speedBit   <= `PMCS_RST_SPEED;
      anEnable   <= `PMCS_RST_ANEN;
      powerDown  <= `PMCS_RST_PDOWN;
      isolate    <= `PMCS_RST_ISO;
      duplexBit  <= `PMCS_RST_DUPLEX;
      colTest    <= `PMCS_RST_COLTEST;
      restartBit <= 1'b0;
      anRestart  <= 1'b0;
      anDoneD    <= 1'b0;
    end else begin
      anDoneD   <= anDone;
      anRestart <= 1'b0;
      if (srBusy) begin
        // Hold defaults for the whole soft reset window
        srCnt      <= srCnt - 4'h1;
        loopBit    <= `PMCS_RST_LOOP;
        speedBit   <= `PMCS_RST_SPEED;
        anEnable   <= `PMCS_RST_ANEN;
        powerDown  <= `PMCS_RST_PDOWN;
        isolate    <= `PMCS_RST_ISO;
        duplexBit  <= `PMCS_RST_DUPLEX;
        colTest    <= `PMCS_RST_COLTEST;
        restartBit <= 1'b0;
      end else if (writeStrobe && regAddr == `PMCS_ADDR_CTRL) begin
        if (writeData[`PMCS_CTL_SRST]) begin
          srCnt <= `PMCS_SRST_CYCLES;
        end
        loopBit   <= writeData[`PMCS_CTL_LOOP];
        speedBit  <= writeData[`PMCS_CTL_SPEED];
        anEnable  <= writeData[`PMCS_CTL_ANEN];
        powerDown <= writeData[`PMCS_CTL_PDOWN];
        isolate   <= writeData[`PMCS_CTL_ISO];
        duplexBit <= writeData[`PMCS_CTL_DUPLEX];
        colTest   <= writeData[`PMCS_CTL_COLTEST];
        // Bits six to zero are dropped on write
        if (writeData[`PMCS_CTL_RESTART] && writeData[`PMCS_CTL_ANEN]) begin
          restartBit <= 1'b1;
          anRestart  <= 1'b1;
        end else if (!writeData[`PMCS_CTL_ANEN]) begin
          restartBit <= 1'b0;
        end else if (anDoneRise) begin
          restartBit <= 1'b0;
        end
      end else if (anDoneRise || !anEnable) begin
        restartBit <= 1'b0;
      end
    end
  end

  assign ctrlWord = {srBusy, loopBit, speedBit, anEnable, powerDown, isolate,
                     restartBit, duplexBit, colTest, 7'h00};

  ////////////////////////////////////////////////////////////////////////
  // Latched status bits
  reg  rfLatch;
  reg  linkLatch;
  reg  jabLatch;
  wire anComplete;

  // Set wins over the clear that a status read brings
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rfLatch   <= 1'b0;
      linkLatch <= 1'b0;
      jabLatch  <= 1'b0;
    end else if (srBusy) begin
      rfLatch   <= 1'b0;
      linkLatch <= 1'b0;
      jabLatch  <= 1'b0;
    end else begin
      if (remoteFault) begin
        rfLatch <= 1'b1;
      end else if (statusRead) begin
        rfLatch <= 1'b0;
      end
      if (!linkUp) begin
        linkLatch <= 1'b0;
      end else if (statusRead) begin
        linkLatch <= 1'b1;
      end
      if (jabber && !portSpeed100) begin
        jabLatch <= 1'b1;
      end else if (statusRead && !jabber) begin
        jabLatch <= 1'b0;
      end
    end
  end

  assign anComplete = anEnable & anDone & ~restartBit;

  assign statWord = {1'b0,
                     capBits,
                     4'h0,
                     1'b1,
                     anComplete,
                     rfLatch,
                     anAble,
                     linkLatch,
                     jabLatch & ~portSpeed100,
                     1'b1};

  ////////////////////////////////////////////////////////////////////////
  // Port mode and MII loopback path
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portSpeed100    <= `PMCS_RST_SPEED;
      portFullDuplex  <= `PMCS_RST_DUPLEX;
      mediaTxEn       <= 1'b0;
      mediaTxData     <= 4'h0;
      loopRxDv        <= 1'b0;
      loopRxData      <= 4'h0;
      softResetActive <= 1'b0;
    end else begin
      softResetActive <= srBusy;
      portSpeed100    <= anEnable ? anSpeed100 : speedBit;
      portFullDuplex  <= anEnable ? anFullDuplex : duplexBit;
      // Medium sees nothing in loopback
      mediaTxEn       <= txEn & ~loopBit;
      mediaTxData     <= loopBit ? 4'h0 : txData;
      loopRxDv        <= txEn & loopBit;
      loopRxData      <= loopBit ? txData : 4'h0;
    end
  end

endmodule // pmcs_phy_mgmt

//--- verif/pmcs_phy_mgmt_monitor.sv
`timescale 1ns/1ps
module pmcs_phy_mgmt_monitor (
  input wire       clk,
  input wire       rst_n,
  input wire       mdcPin,
  input wire       mdioOeN,
  input wire       txEn,
  input wire [3:0] txData,
  input wire       mediaTxEn,
  input wire       loopRxDv,
  input wire [3:0] loopRxData,
  input wire       anSpeed100,
  input wire       anFullDuplex,
  input wire       portSpeed100,
  input wire       portFullDuplex,
  input wire       anEnable,
  input wire       anRestart,
  input wire       powerDown,
  input wire       isolate,
  input wire       softResetActive
);
  reg [7:0] idleCnt;
  reg       mdcLast;
  // Cycles since MDC last moved; saturates so long idle never wraps
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt <= 8'h00;
      mdcLast <= 1'b0;
    end else begin
      mdcLast <= mdcPin;
      if (mdcPin != mdcLast) idleCnt <= 8'h00;
      else if (idleCnt != 8'hFF) idleCnt <= idleCnt + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Loopback quiets the medium and echoes the transmit nibble
  a_loop_isolate: assert property (loopRxDv |-> !mediaTxEn)
    else $error("medium driven in loopback");
  a_loop_echo: assert property (loopRxDv |-> $past(txEn) && loopRxData == $past(txData))
    else $error("loopback data wrong");
  // Negotiated result wins while negotiation is on
  a_an_follow: assert property (
    $past(rst_n) && anEnable && $past(anEnable) && !softResetActive && !$past(softResetActive)
    && $stable(anSpeed100) && $stable(anFullDuplex)
    |-> portSpeed100 == anSpeed100 && portFullDuplex == anFullDuplex)
    else $error("forced mode used during negotiation");
  a_restart_gate: assert property (anRestart |-> anEnable)
    else $error("restart without negotiation");
  // Line released once MDC has stood still for a while
  a_idle_release: assert property (idleCnt > 8'h28 |-> mdioOeN)
    else $error("data line driven while idle");
  a_drive_frame: assert property ($fell(mdioOeN) |-> idleCnt < 8'h08)
    else $error("drive started outside a frame");
  // Soft reset window length and defaults
  a_srst_len: assert property (
    $rose(softResetActive) |-> softResetActive [*7] ##[1:3] !softResetActive)
    else $error("soft reset window length wrong");
  a_srst_dflt: assert property (
    softResetActive && $past(softResetActive) |-> anEnable && !powerDown && !isolate)
    else $error("defaults not applied in soft reset");
endmodule // pmcs_phy_mgmt_monitor

bind pmcs_phy_mgmt pmcs_phy_mgmt_monitor u_mon (.*);

//--- verif/pmcs_mgmt_master.sv
`timescale 1ns/1ps
// Management master; MDC rests low between frames
module pmcs_mgmt_master (
  input  wire clk,
  input  wire mdioOut,
  input  wire mdioOeN,
  output reg  mdcPin,
  output wire mdioIn
);
  reg mDrv = 1'b0;
  reg mVal = 1'b1;
  // Shared line; pull-up when neither side drives
  assign mdioIn = !mdioOeN ? mdioOut : (mDrv ? mVal : 1'b1);
  initial begin
    mdcPin = 1'b0;
  end
  // Half MDC period: 4 core cycles, 200 ns per bit
  task half;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) @(negedge clk);
    end
  endtask
  // One frame of 32 bits plus a spare clock
  task xfer(input [1:0] op, input [4:0] phy, input [4:0] ra, input [15:0] wd,
            output [15:0] rd);
    reg [31:0] f;
    integer    i;
    begin
      f = {2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0000;
      for (i = 31; i >= 0; i = i - 1) begin
        mDrv = !(op == 2'h2 && i < 18);
        mVal = f[i];
        half;
        mdcPin = 1'b1;
        if (i < 16) rd = {rd[14:0], mdioIn};
        half;
        mdcPin = 1'b0;
      end
      mDrv = 1'b0;
      half;
      mdcPin = 1'b1;
      half;
      mdcPin = 1'b0;
    end
  endtask
endmodule // pmcs_mgmt_master

//--- verif/pmcs_phy_mgmt_tb_top.sv
`timescale 1ns/1ps
`include "pmcs_regs.vh"
module pmcs_phy_mgmt_tb_top;
  reg         clk;
  reg         rst_n = 1'b0;
  reg  [3:0]  strapCap = 4'h0;
  reg         strapAnAble = 1'b0;
  reg         linkUp = 1'b0, remoteFault = 1'b0, jabber = 1'b0, anDone = 1'b0;
  reg         anSpeed100 = 1'b0, anFullDuplex = 1'b0, txEn = 1'b0;
  reg  [3:0]  txData = 4'h0;
  wire        mdcPin, mdioIn, mdioOut, mdioOeN, mediaTxEn, loopRxDv;
  wire [3:0]  mediaTxData, loopRxData;
  wire        portSpeed100, portFullDuplex, anEnable, anRestart;
  wire        powerDown, isolate, softResetActive;
  reg  [7:0]  lfsr = 8'h0C;
  reg  [15:0] mCtrl = 16'h3000;
  reg         mLink = 1'b0, mRf = 1'b0, mJab = 1'b0;
  reg  [15:0] rdv;
  integer     badCount = 0, nCompared = 0, pulses = 0, srCycles = 0, i, m;

  pmcs_phy_mgmt dut (.clk(clk), .rst_n(rst_n), .mdcPin(mdcPin), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOeN(mdioOeN), .strapCap(strapCap), .strapAnAble(strapAnAble),
    .linkUp(linkUp), .remoteFault(remoteFault), .jabber(jabber), .anDone(anDone),
    .anSpeed100(anSpeed100), .anFullDuplex(anFullDuplex), .txEn(txEn), .txData(txData),
    .mediaTxEn(mediaTxEn), .mediaTxData(mediaTxData), .loopRxDv(loopRxDv),
    .loopRxData(loopRxData), .portSpeed100(portSpeed100), .portFullDuplex(portFullDuplex),
    .anEnable(anEnable), .anRestart(anRestart), .powerDown(powerDown), .isolate(isolate),
    .softResetActive(softResetActive));
  pmcs_mgmt_master u_mst (.clk(clk), .mdioOut(mdioOut), .mdioOeN(mdioOeN),
    .mdcPin(mdcPin), .mdioIn(mdioIn));

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Count restart pulses and soft reset window cycles
  always @(posedge clk) begin
    if (anRestart === 1'b1) pulses = pulses + 1;
    if (softResetActive === 1'b1) srCycles = srCycles + 1;
  end
  function [7:0] nextLfsr(input [7:0] v);
    nextLfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      nCompared = nCompared + 1;
      if (seen !== exp) begin
        badCount = badCount + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rd(input [4:0] ra, input [15:0] exp);
    begin
      u_mst.xfer(`PMCS_OP_READ, `PMCS_PHY_ADDR, ra, 16'h0000, rdv);
      check("mgmt read", rdv, exp);
    end
  endtask
  // Status read; model latches then follow the read clear
  task rdStat;
    begin
      rd(`PMCS_ADDR_STAT, {1'b0, strapCap, 4'h0, 1'b1, mCtrl[12] & anDone, mRf,
        strapAnAble, mLink, mJab, 1'b1});
      mLink = linkUp;
      mRf = mRf & remoteFault;
      mJab = mJab & jabber;
    end
  endtask
  task wr(input [15:0] d);
    begin
      u_mst.xfer(`PMCS_OP_WRITE, `PMCS_PHY_ADDR, `PMCS_ADDR_CTRL, d, rdv);
      mCtrl = d & 16'h7F80;
      mCtrl[9] = d[9] & d[12];
    end
  endtask
  task endSim;
    begin
      if (badCount == 0 && nCompared > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // Watchdog sized well past the frame count below
  initial begin
    repeat (40000) @(posedge clk);
    badCount = badCount + 1;
    endSim;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    lfsr = nextLfsr(lfsr);
    strapCap = lfsr[3:0];
    strapAnAble = lfsr[4];
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    rd(`PMCS_ADDR_CTRL, mCtrl);
    rdStat;
    linkUp = 1'b1;
    repeat (2) rdStat;
    linkUp = 1'b0;
    repeat (4) @(negedge clk);
    linkUp = 1'b1;
    mLink = 1'b0;
    repeat (2) rdStat;
    remoteFault = 1'b1;
    mRf = 1'b1;
    repeat (2) rdStat;
    remoteFault = 1'b0;
    repeat (2) rdStat;
    for (m = 0; m < 2; m = m + 1) begin
      anSpeed100 = m[0];
      jabber = 1'b1;
      mJab = !m[0];
      repeat (2) @(negedge clk);
      jabber = 1'b0;
      repeat (2) rdStat;
      check("speed", portSpeed100, m[0]);
    end
    anDone = 1'b1;
    rdStat;
    anDone = 1'b0;
    wr(16'h3200);
    check("restart", pulses, 1);
    rd(`PMCS_ADDR_CTRL, mCtrl);
    anDone = 1'b1;
    mCtrl[9] = 1'b0;
    rd(`PMCS_ADDR_CTRL, mCtrl);
    // Forced speed and duplex, with an inert restart request
    for (i = 0; i < 4; i = i + 1) begin
      anSpeed100 = !i[1];
      anFullDuplex = !i[0];
      wr({2'b00, i[1], 4'b0001, i[0], 8'h00});
      check("forced", {portSpeed100, portFullDuplex, anEnable}, {i[1], i[0], 1'b0});
      rd(`PMCS_ADDR_CTRL, mCtrl);
      rdStat;
    end
    check("restart", pulses, 1);
    // Normal path then loopback with random nibbles
    for (m = 0; m < 2; m = m + 1) begin
      wr(m[0] ? 16'h4000 : 16'h0000);
      for (i = 0; i < 6; i = i + 1) begin
        lfsr = nextLfsr(lfsr);
        txEn = 1'b1;
        txData = lfsr[3:0];
        @(negedge clk);
        check("loop rx", {loopRxDv, loopRxData}, {m[0], lfsr[3:0] & {4{m[0]}}});
        check("medium", {mediaTxEn, mediaTxData}, {!m[0], lfsr[3:0] & {4{!m[0]}}});
      end
      txEn = 1'b0;
    end
    // Storage-only control bits, put back to defaults by the soft reset below
    wr(16'h0C80);
    check("pd iso", {powerDown, isolate}, 2'b11);
    rd(`PMCS_ADDR_CTRL, mCtrl);
    remoteFault = 1'b1;
    repeat (2) @(negedge clk);
    remoteFault = 1'b0;
    wr(16'h8800);
    {mCtrl, mRf, mLink, mJab} = {16'h3000, 3'h0};
    // Window still stands for its last cycle when the write task returns
    repeat (2) @(negedge clk);
    check("srst len", srCycles, `PMCS_SRST_CYCLES);
    rd(`PMCS_ADDR_CTRL, mCtrl);
    rdStat;
    u_mst.xfer(`PMCS_OP_WRITE, 5'h01, `PMCS_ADDR_CTRL, 16'h0100, rdv);
    u_mst.xfer(`PMCS_OP_READ, 5'h01, `PMCS_ADDR_CTRL, 16'h0000, rdv);
    check("other phy", rdv, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    rd(`PMCS_ADDR_CTRL, mCtrl);
    endSim;
  end
endmodule // pmcs_phy_mgmt_tb_top
